// ==== rtl/ltsl_top.v ====
// remote-open, line pickup and potential loss supervision
`timescale 1ns/10ps
`default_nettype none
`include "ltsl_map.vh"
// Contract
// R1: remote-open trip needs fault, remote opening, and fault held for security delay
// R2: charging current without fault sets a self-holding charging memory
// R3: charging memory blocks remote-opening recognition regardless of fault
// R4: active fault detector inhibits setting the charging memory
// R5: charging current present when any of three phase flags asserted
// R6: dead line (no current, no voltage) enables line pickup after 150 ms
// R7: enable plus closing current detector forms line-pickup trip request
// R8: bypass trips immediately, otherwise request must last 45 ms
// R9: open pole or pole disagreement suppresses all line-pickup tripping
// R10: voltage pickup for 25 ms fast-resets the line-pickup enable timer
// R11: zone 2 distance output with line-pickup enable also trips
// R12: potential loss timer runs on no voltage, load current, no fault, no open pole
// R13: potential loss output seals in while voltage stays dropped out
// R14: voltage pickup releases seal-in and clears potential loss output
// R15: block select: alarm plus block distance/directional, else alarm only
// R16: open poles disable potential loss detection
// R17: during block, phase and nondirectional ground functions still trip
// R18: directional supervision selectable separately for instant and time ground
// R19: timers count whole ms from common tick; reset clears all
// R20: remote-open and potential loss delays are programmable ms inputs
module ltsl_top #(
    parameter integer MS_W = `LTSL_MS_WIDTH,
    parameter integer TICK_CYCLES = `LTSL_TICK_CYCLES
) (
    // clock and reset
    input wire i_clk,
    input wire i_reset,
    // measuring detector flags
    input wire i_fault_detector_flag,
    input wire [2:0] i_charging_current_det,
    input wire i_remote_open_sense,
    input wire i_load_current_detector,
    input wire i_pos_seq_voltage_detector,
    input wire i_closing_current_detector,
    input wire i_open_pole,
    input wire i_zone2_distance,
    input wire i_distance_directional_trip,
    input wire i_phase_overcurrent_instant,
    input wire i_ground_overcurrent_instant,
    input wire i_ground_time_overcurrent,
    input wire i_neg_seq_directional_unit,
    // settings
    input wire i_closing_delay_bypass_sel,
    input wire i_potential_loss_block_sel,
    input wire i_instant_ground_dir_sel,
    input wire i_time_ground_dir_sel,
    input wire [MS_W-1:0] i_remote_open_delay_ms,
    input wire [MS_W-1:0] i_potential_loss_delay_ms,
    // outputs
    output reg o_remote_open_trip,
    output reg o_line_pickup_enable,
    output reg o_line_pickup_trip,
    output reg o_potential_loss_detect,
    output reg o_critical_alarm,
    output reg o_distance_block,
    output reg o_trip_bus
);
    localparam [MS_W-1:0] DEAD_MS = `LTSL_DEAD_LINE_MS;
    localparam [MS_W-1:0] CLOSE_MS = `LTSL_CLOSE_DELAY_MS;
    localparam [MS_W-1:0] VQUAL_MS = `LTSL_VQUAL_MS;

    wire tick;
    wire charging_any;
    reg charge_mem_q;
    wire remote_opened;
    wire rod_done;
    wire dead_done;
    wire vqual_done;
    wire close_done;
    wire pll_done;
    reg lp_enable_q;
    wire lp_request;
    wire lp_trip_d;
    wire pll_run;
    reg pll_seal_q;
    wire pll_out;
    wire blocking;
    wire inst_gnd_ok;
    wire time_gnd_ok;
    wire dist_ok;
    wire trip_d;

    ltsl_ms_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .o_tick(tick)
    ); // see R19

    // remote-open detection
    assign charging_any = |i_charging_current_det; // see R5

    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            charge_mem_q <= 1'b0;
        end
        else
        begin
            // set only without fault, hold while charging current stays
            charge_mem_q <= charging_any & (~i_fault_detector_flag | charge_mem_q); // see R2 R4
        end
    end

    // memory blocks recognition whatever the fault state
    assign remote_opened = charging_any & i_remote_open_sense & ~charge_mem_q; // see R3

    ltsl_ms_timer #(
        .W(MS_W)
    ) u_remote_open_security_timer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_tick(tick),
        .i_run(i_fault_detector_flag & remote_opened),
        .i_delay(i_remote_open_delay_ms),
        .o_done(rod_done)
    ); // see R1 R20

    // line pickup
    ltsl_ms_timer #(
        .W(MS_W)
    ) u_dead_line_enable_timer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_tick(tick),
        .i_run(~i_load_current_detector & ~i_pos_seq_voltage_detector),
        .i_delay(DEAD_MS),
        .o_done(dead_done)
    ); // see R6

    ltsl_ms_timer #(
        .W(MS_W)
    ) u_voltage_qualify_timer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_tick(tick),
        .i_run(i_pos_seq_voltage_detector),
        .i_delay(VQUAL_MS),
        .o_done(vqual_done)
    ); // see R10

    // enable sets on dead-line expiry, fast reset by voltage qualify
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            lp_enable_q <= 1'b0;
        end
        else if (vqual_done)
        begin
            lp_enable_q <= 1'b0; // see R10
        end
        else if (dead_done)
        begin
            lp_enable_q <= 1'b1; // see R6
        end
    end

    assign lp_request = lp_enable_q & i_closing_current_detector; // see R7

    ltsl_ms_timer #(
        .W(MS_W)
    ) u_closing_trip_delay_timer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_tick(tick),
        .i_run(lp_request),
        .i_delay(CLOSE_MS),
        .o_done(close_done)
    ); // see R8

    assign lp_trip_d = ~i_open_pole &
        ((lp_request & (i_closing_delay_bypass_sel | close_done)) |
         (i_zone2_distance & lp_enable_q)); // see R8 R9 R11

    // potential loss detection
    assign pll_run = ~i_pos_seq_voltage_detector & i_load_current_detector &
        ~i_fault_detector_flag & ~i_open_pole; // see R12 R16

    ltsl_ms_timer #(
        .W(MS_W)
    ) u_potential_loss_timer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_tick(tick),
        .i_run(pll_run),
        .i_delay(i_potential_loss_delay_ms),
        .o_done(pll_done)
    ); // see R12 R20

    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            pll_seal_q <= 1'b0;
        end
        else
        begin
            // seal while voltage stays low, release on voltage pickup
            pll_seal_q <= ~i_pos_seq_voltage_detector & (pll_done | pll_seal_q); // see R13 R14
        end
    end

    assign pll_out = ~i_pos_seq_voltage_detector & (pll_done | pll_seal_q); // see R13 R14
    assign blocking = pll_out & i_potential_loss_block_sel; // see R15

    // directional supervision per ground function
    assign inst_gnd_ok = i_ground_overcurrent_instant &
        (i_instant_ground_dir_sel ? (i_neg_seq_directional_unit & ~blocking) : 1'b1); // see R17 R18
    assign time_gnd_ok = i_ground_time_overcurrent &
        (i_time_ground_dir_sel ? (i_neg_seq_directional_unit & ~blocking) : 1'b1); // see R17 R18
    assign dist_ok = i_distance_directional_trip & ~blocking; // see R15

    assign trip_d = rod_done | lp_trip_d | dist_ok | i_phase_overcurrent_instant |
        inst_gnd_ok | time_gnd_ok; // see R17

    // registered outputs
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_remote_open_trip <= 1'b0;
            o_line_pickup_enable <= 1'b0;
            o_line_pickup_trip <= 1'b0;
            o_potential_loss_detect <= 1'b0;
            o_critical_alarm <= 1'b0;
            o_distance_block <= 1'b0;
            o_trip_bus <= 1'b0;
        end
        else
        begin
            o_remote_open_trip <= rod_done; // see R1
            o_line_pickup_enable <= lp_enable_q;
            o_line_pickup_trip <= lp_trip_d;
            o_potential_loss_detect <= pll_out;
            o_critical_alarm <= pll_out; // see R15
            o_distance_block <= blocking;
            o_trip_bus <= trip_d;
        end
    end
endmodule
`default_nettype wire

// ==== common/ltsl_map.vh ====
// constants for the line trip supervision logic
`ifndef LTSL_MAP_VH
`define LTSL_MAP_VH
`define LTSL_CLK_HZ 125000000
`define LTSL_MS_PER_S 1000
`define LTSL_TICK_CYCLES (`LTSL_CLK_HZ / `LTSL_MS_PER_S)
`define LTSL_DEAD_LINE_MS 150
`define LTSL_CLOSE_DELAY_MS 45
`define LTSL_VQUAL_MS 25
`define LTSL_MS_WIDTH 16
`define LTSL_RST_MS 16'h0000
`endif

// ==== rtl/ltsl_ms_tick.v ====
// millisecond tick generator
`timescale 1ns/10ps
`default_nettype none
module ltsl_ms_tick #(
    parameter integer CYCLES = 125000
) (
    // clock and reset
    input wire i_clk,
    input wire i_reset,
    // tick out
    output reg o_tick
);
    reg [31:0] cnt_q;
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cnt_q <= 32'h0000_0000;
            o_tick <= 1'b0;
        end
        else if (cnt_q == CYCLES - 1)
        begin
            cnt_q <= 32'h0000_0000;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h0000_0001;
            o_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/ltsl_ms_timer.v ====
// pickup delay timer counted in ms ticks
`timescale 1ns/10ps
`default_nettype none
module ltsl_ms_timer #(
    parameter integer W = 16
) (
    // clock and reset
    input wire i_clk,
    input wire i_reset,
    // control
    input wire i_tick,
    input wire i_run,
    input wire [W-1:0] i_delay,
    // expired level
    output reg o_done
);
    reg [W-1:0] cnt_q;
    always @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cnt_q <= {W{1'b0}};
            o_done <= 1'b0;
        end
        else if (!i_run)
        begin
            cnt_q <= {W{1'b0}};
            o_done <= 1'b0;
        end
        else if (cnt_q >= i_delay)
        begin
            o_done <= 1'b1;
        end
        else if (i_tick)
        begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            o_done <= (cnt_q + {{(W-1){1'b0}}, 1'b1}) >= i_delay;
        end
    end
endmodule
`default_nettype wire

// ==== verification/ltsl_meas_model.sv ====
// measuring-function model turning a line scene into detector flags
`timescale 1ns/10ps
`default_nettype none
module ltsl_meas_model (
    // scene: 0 live, 1 dead, 2 fault, 3 potential lost
    input wire logic [1:0] i_scene,
    // detector flags
    output logic o_fault,
    output logic o_load,
    output logic o_volt
);
    assign o_volt = (i_scene == 2'h0);
    assign o_load = (i_scene != 2'h1);
    assign o_fault = (i_scene == 2'h2);
endmodule
`default_nettype wire

// ==== verification/ltsl_assertions.sv ====
// assertions on the line trip supervision ports
`timescale 1ns/10ps
`default_nettype none
module ltsl_checker (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // detector flags and settings
    input wire logic i_fault_detector_flag,
    input wire logic i_load_current_detector,
    input wire logic i_pos_seq_voltage_detector,
    input wire logic i_closing_current_detector,
    input wire logic i_open_pole,
    input wire logic i_zone2_distance,
    input wire logic i_closing_delay_bypass_sel,
    input wire logic i_potential_loss_block_sel,
    // outputs
    input wire logic o_remote_open_trip,
    input wire logic o_line_pickup_enable,
    input wire logic o_line_pickup_trip,
    input wire logic o_potential_loss_detect,
    input wire logic o_critical_alarm,
    input wire logic o_distance_block,
    input wire logic o_trip_bus
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_close;
        o_line_pickup_enable && i_closing_current_detector && !i_open_pole;
    endsequence
    sequence s_live;
        i_pos_seq_voltage_detector [*3];
    endsequence
    rot_fault_a: assert property (
        !i_fault_detector_flag [*3] |-> !o_remote_open_trip) else $error("rot no fault");
    lp_enable_a: assert property (
        $rose(o_line_pickup_enable) |->
        $past(!i_load_current_detector && !i_pos_seq_voltage_detector)) else $error("lp enable");
    lp_bypass_a: assert property (
        s_close [*2] ##0 i_closing_delay_bypass_sel |-> ##[1:2] o_line_pickup_trip)
        else $error("lp bypass");
    lp_block_a: assert property (
        i_open_pole [*2] |-> !o_line_pickup_trip) else $error("lp open pole");
    lp_zone2_a: assert property (
        o_line_pickup_enable && i_zone2_distance && !i_open_pole && !o_distance_block
        |-> ##[1:2] o_trip_bus) else $error("zone2 trip");
    pl_seal_a: assert property (
        (o_potential_loss_detect && !i_pos_seq_voltage_detector) [*2] |=>
        o_potential_loss_detect) else $error("pl seal");
    pl_clear_a: assert property (
        s_live |-> !o_potential_loss_detect) else $error("pl clear");
    blk_sel_a: assert property (
        !i_potential_loss_block_sel [*2] |-> !o_distance_block) else $error("block sel");
    alarm_tie_a: assert property (
        o_critical_alarm == o_potential_loss_detect) else $error("alarm");
endmodule
bind ltsl_top ltsl_checker i_ltsl_checker (.*);
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the line trip supervision block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [1:0] scene = 2'h0;
    logic [2:0] cc = 3'h0;
    logic [4:0] ctl = 5'h00;
    logic [3:0] oc = 4'h0;
    // {directional permission, time ground supervised}
    logic [1:0] dirs = 2'h0;
    wire flt, load, volt, rot, lpen, lpt, pl, crit, blk, tb;
    wire [5:0] outs = {rot, lpen, lpt, pl, blk, tb};
    int n_errors = 0;
    int num_checks = 0;
    // scene, cc, {close, pole, z2, bypass, blocksel}, {dist, ph, gnd, tgnd}, cycles, outs
    logic [28:0] rows [0:23] = '{
        {2'h0, 3'h0, 5'h01, 4'h0, 9'h028, 6'h00},
        {2'h1, 3'h0, 5'h08, 4'h0, 9'h140, 6'h10},
        {2'h1, 3'h0, 5'h1a, 4'h0, 9'h008, 6'h10},
        {2'h1, 3'h0, 5'h10, 4'h0, 9'h028, 6'h10},
        {2'h1, 3'h0, 5'h10, 4'h0, 9'h046, 6'h19},
        {2'h1, 3'h0, 5'h02, 4'h0, 9'h004, 6'h10},
        {2'h1, 3'h0, 5'h12, 4'h0, 9'h004, 6'h19},
        {2'h1, 3'h0, 5'h04, 4'h0, 9'h008, 6'h19},
        {2'h0, 3'h0, 5'h00, 4'h0, 9'h014, 6'h10},
        {2'h0, 3'h0, 5'h00, 4'h0, 9'h032, 6'h00},
        {2'h3, 3'h0, 5'h01, 4'h8, 9'h032, 6'h06},
        {2'h3, 3'h0, 5'h01, 4'h2, 9'h004, 6'h06},
        {2'h3, 3'h0, 5'h01, 4'h1, 9'h004, 6'h07},
        {2'h2, 3'h0, 5'h01, 4'h4, 9'h008, 6'h07},
        {2'h3, 3'h0, 5'h00, 4'h8, 9'h004, 6'h05},
        {2'h0, 3'h0, 5'h00, 4'h0, 9'h006, 6'h00},
        {2'h3, 3'h0, 5'h08, 4'h0, 9'h032, 6'h00},
        {2'h2, 3'h4, 5'h00, 4'h0, 9'h01e, 6'h00},
        {2'h2, 3'h4, 5'h00, 4'h0, 9'h014, 6'h21},
        {2'h0, 3'h1, 5'h00, 4'h0, 9'h006, 6'h00},
        {2'h2, 3'h1, 5'h00, 4'h0, 9'h032, 6'h00},
        {2'h2, 3'h2, 5'h00, 4'h0, 9'h032, 6'h00},
        {2'h2, 3'h0, 5'h00, 4'h0, 9'h004, 6'h00},
        {2'h2, 3'h2, 5'h00, 4'h0, 9'h032, 6'h21}
    };

    ltsl_meas_model i_ltsl_meas_model (.i_scene(scene), .o_fault(flt), .o_load(load),
        .o_volt(volt));

    ltsl_top #(.TICK_CYCLES(2)) i_ltsl_top (.i_clk(i_clk), .i_reset(i_reset),
        .i_fault_detector_flag(flt), .i_charging_current_det(cc), .i_remote_open_sense(1'b1),
        .i_load_current_detector(load), .i_pos_seq_voltage_detector(volt),
        .i_closing_current_detector(ctl[4]), .i_open_pole(ctl[3]), .i_zone2_distance(ctl[2]),
        .i_distance_directional_trip(oc[3]), .i_phase_overcurrent_instant(oc[2]),
        .i_ground_overcurrent_instant(oc[1]), .i_ground_time_overcurrent(oc[0]),
        .i_neg_seq_directional_unit(dirs[1]), .i_closing_delay_bypass_sel(ctl[1]),
        .i_potential_loss_block_sel(ctl[0]), .i_instant_ground_dir_sel(1'b1),
        .i_time_ground_dir_sel(dirs[0]), .i_remote_open_delay_ms(16'h0014),
        .i_potential_loss_delay_ms(16'h0014), .o_remote_open_trip(rot),
        .o_line_pickup_enable(lpen), .o_line_pickup_trip(lpt), .o_potential_loss_detect(pl),
        .o_critical_alarm(crit), .o_distance_block(blk), .o_trip_bus(tb));

    task automatic check(input string what, input logic [5:0] got, input logic [5:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test;
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
        forever #4 i_clk = ~i_clk;

    initial
    begin
        repeat (10) @(negedge i_clk);
        i_reset = 1'b0;
        check("reset", outs, 6'h00);
        foreach (rows[k])
        begin
            {scene, cc, ctl, oc} = rows[k][28:15];
            repeat (rows[k][14:6]) @(negedge i_clk);
            check("row", outs, rows[k][5:0]);
            check("alarm", crit, rows[k][2]);
        end
        i_reset = 1'b1;
        @(negedge i_clk);
        check("mid reset", outs, 6'h00);
        i_reset = 1'b0;
        repeat (30) @(negedge i_clk);
        check("restart", outs, 6'h00);
        repeat (20) @(negedge i_clk);
        check("retrip", outs, 6'h21);
        scene = 2'h0;
        cc = 3'h0;
        oc = 4'h2;
        dirs = 2'h2;
        repeat (4) @(negedge i_clk);
        check("dir inst", outs, 6'h01);
        oc = 4'h1;
        dirs = 2'h1;
        repeat (4) @(negedge i_clk);
        check("dir time", outs, 6'h00);
        stop_test();
    end

    initial
    begin
        #20000;
        n_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
